// ---- sie_pkg.sv ----
// Contract
// - gate mode: output low while gate open
// - gate reset: each opening needs fresh reset
// - manual reset: accept one 0-to-1 rise
// - monitored reset: accept rise then fall
// - test outputs pulsed, shorts detected from returns
// - startup test (not in lock mode): hold low until release-actuate
// - debounce inputs, filter 3 to 250 ms
// - simultaneity: fault when channels skew too long
// - error output asserted on any fault
// - lock mode: high only while locked
// - lock contacts: single NC, double NC, NO+NC
// - key mode: high only while key turned
// - key contacts: single or double NO
// - key reset: each activation needs a reset
// - key startup: release then activate
// - curtain mode: low while area occupied
// - curtain mode uses no test outputs
// - curtain mode: simultaneity always checked
// - curtain reset: each occupation needs reset
// - gate startup: open then close
package sie_pkg;

  // timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int MS_IN_NS       = 1000000;
  localparam int CYC_PER_MS     = MS_IN_NS / CLK_PERIOD_NS;
  localparam int FILTER_MIN_MS  = 3;
  localparam int FILTER_MAX_MS  = 250;
  localparam int TEST_PERIOD_MS = 10;
  localparam int TEST_LOW_NS    = 100000;
  localparam int TEST_LOW_CYC   = (TEST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int N_CHANNELS     = 2;
  localparam int MS_W           = 8;

  // reset values
  localparam logic [N_CHANNELS-1:0] FILT_RESET = 2'h0;
  localparam logic [N_CHANNELS-1:0] TEST_IDLE  = 2'h3;

  typedef enum logic [1:0] {
    SIE_MODE_GATE,
    SIE_MODE_LOCK,
    SIE_MODE_KEY,
    SIE_MODE_CURTAIN
  } sie_mode_t;

  typedef enum logic [2:0] {
    SIE_IN_SINGLE_NC,
    SIE_IN_DOUBLE_NC,
    SIE_IN_NC_NO,
    SIE_IN_SINGLE_NO,
    SIE_IN_DOUBLE_NO
  } sie_contact_t;

  typedef struct packed {
    sie_mode_t         mode;
    sie_contact_t      contact;
    logic              reset_en;
    logic              reset_monitored;
    logic              test_en;
    logic              startup_en;
    logic              simul_en;
    logic              error_en;
    logic [MS_W-1:0]   filter_ms;
    logic [MS_W-1:0]   simul_ms;
  } sie_cfg_t;

  typedef struct packed {
    logic simul_fault;
    logic short_fault;
    logic await_reset;
    logic startup_pending;
  } sie_status_t;

endpackage

// ---- sie_filter.sv ----
`timescale 1ns/1ps
module sie_filter #(
  parameter int N = sie_pkg::N_CHANNELS
) (
  // clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_reset_n,
  // timing
  input  wire logic                    i_ms_tick,
  input  wire logic [sie_pkg::MS_W-1:0] i_filter_ms,
  // contacts
  input  wire logic [N-1:0]            i_raw,
  output logic      [N-1:0]            o_filt
);
  import sie_pkg::*;

  genvar c;
  generate
    for (c = 0; c < N; c++) begin : g_ch
      logic [MS_W-1:0] cnt_q;
      logic            filt_q;
      wire             differs = i_raw[c] != filt_q;
      wire             expired = i_ms_tick && (cnt_q + 8'h01 >= i_filter_ms);

      // a level must hold unchanged through filter_ms ms ticks, so at least filter_ms - 1 ms, before it passes
      always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
          cnt_q  <= '0;
          filt_q <= FILT_RESET[c];
        end else if (!differs) begin
          cnt_q <= '0;
        end else if (expired) begin
          cnt_q  <= '0;
          filt_q <= i_raw[c];
        end else if (i_ms_tick) begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
      assign o_filt[c] = filt_q;
    end
  endgenerate
endmodule // sie_filter

// ---- sie_reset_detect.sv ----
`timescale 1ns/1ps
module sie_reset_detect (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // control
  input  wire logic i_monitored,
  input  wire logic i_arm,
  input  wire logic i_reset_input,
  // result
  output logic      o_accept
);
  import sie_pkg::*;

  logic prev_q;
  logic rose_q;

  wire rise = i_reset_input && !prev_q;
  wire fall = !i_reset_input && prev_q;

  // an edge is only counted while armed, so a button held through closing needs a new press
  assign o_accept = i_arm && (i_monitored ? (rose_q && fall) : rise);

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_q <= 1'b0;
      rose_q <= 1'b0;
    end else begin
      prev_q <= i_reset_input;
      if (!i_arm || o_accept) begin
        rose_q <= 1'b0;
      end else if (rise) begin
        rose_q <= 1'b1;
      end
    end
  end
endmodule // sie_reset_detect

// ---- sie_evaluator.sv ----
`timescale 1ns/1ps
module sie_evaluator #(
  parameter int P_CYC_PER_MS = sie_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_reset_n,
  // configuration
  input  wire sie_pkg::sie_cfg_t    i_cfg,
  // field contacts
  input  wire logic                 i_first_contact_input,
  input  wire logic                 i_second_contact_input,
  input  wire logic                 i_reset_input,
  // test pulse drive
  output logic [sie_pkg::N_CHANNELS-1:0] o_test_out,
  // results
  output logic                      o_safe,
  output logic                      o_error,
  output sie_pkg::sie_status_t      o_status
);
  import sie_pkg::*;

  typedef enum logic [2:0] {
    ST_TEST_OFF,
    ST_TEST_ON,
    ST_OFF,
    ST_ARMED,
    ST_ON
  } sie_state_t;

  // the pulse scales with the time base; the floor keeps it long enough for a return to follow
  localparam int LOW_FLOOR  = 10;
  localparam int LOW_SCALED = (TEST_LOW_CYC * P_CYC_PER_MS) / CYC_PER_MS;
  localparam int LOW_CYC    = (LOW_SCALED < LOW_FLOOR) ? LOW_FLOOR : LOW_SCALED;
  localparam int TICK_W     = $clog2(P_CYC_PER_MS + 1);
  localparam int LOW_W      = $clog2(LOW_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(P_CYC_PER_MS - 1);
  localparam logic [LOW_W-1:0]  LOW_LOAD  = LOW_W'(LOW_CYC);
  localparam logic [MS_W-1:0]   TP_LAST   = MS_W'(TEST_PERIOD_MS - 1);
  localparam logic [MS_W-1:0]   FMIN      = MS_W'(FILTER_MIN_MS);
  localparam logic [MS_W-1:0]   FMAX      = MS_W'(FILTER_MAX_MS);

  // millisecond time base
  logic [TICK_W-1:0] tick_cnt_q;
  logic              ms_tick_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_q <= '0;
      ms_tick_q  <= 1'b0;
    end else begin
      ms_tick_q  <= tick_cnt_q == TICK_LAST;
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + TICK_W'(1);
    end
  end

  // mode decode
  wire [1:0] raw       = {i_second_contact_input, i_first_contact_input};
  wire       is_gate   = i_cfg.mode == SIE_MODE_GATE;
  wire       is_lock   = i_cfg.mode == SIE_MODE_LOCK;
  wire       is_key    = i_cfg.mode == SIE_MODE_KEY;
  wire       is_curt   = i_cfg.mode == SIE_MODE_CURTAIN;
  wire       mixed     = is_lock && (i_cfg.contact == SIE_IN_NC_NO);
  wire       lock_two  = is_lock && (i_cfg.contact == SIE_IN_DOUBLE_NC || mixed);
  wire       key_two   = is_key && (i_cfg.contact == SIE_IN_DOUBLE_NO);
  wire       two_ch    = lock_two || key_two || is_curt;
  wire       reset_on  = i_cfg.reset_en && !is_lock;
  wire       start_on  = i_cfg.startup_en && !is_lock;
  // the curtain checks its own outputs, so pulsing them would only trip it
  wire       test_on   = i_cfg.test_en && !is_curt;
  wire       simul_on  = two_ch && (i_cfg.simul_en || is_curt);

  // filter time is clamped so a bad setting cannot remove debouncing
  wire [MS_W-1:0] filter_ms = (i_cfg.filter_ms < FMIN) ? FMIN :
                              (i_cfg.filter_ms > FMAX) ? FMAX : i_cfg.filter_ms;

  // test pulse generator
  logic [MS_W-1:0]        tp_ms_q;
  logic [LOW_W-1:0]       tp_low_q;
  logic                   tp_ch_q;
  logic [N_CHANNELS-1:0]  test_out_q;
  logic [N_CHANNELS-1:0]  test_prev_q;
  logic [N_CHANNELS-1:0]  hold_q;
  logic                   other_pre_q;
  logic                   short_q;

  wire tp_start   = test_on && ms_tick_q && (tp_ms_q == TP_LAST);
  wire next_ch    = two_ch ? !tp_ch_q : 1'b0;
  wire pulse_live = tp_low_q != '0;
  wire pulse_end  = tp_low_q == LOW_W'(1);
  wire tested_raw = raw[tp_ch_q];
  wire other_raw  = raw[!tp_ch_q];
  // a closed contact must follow the pulse low; a high return means a short to a live line,
  // and the other channel dropping with it means the two lines are bridged
  wire short_evt  = test_on && pulse_end &&
                    (tested_raw || (two_ch && other_pre_q && !other_raw));

  genvar c;
  generate
    for (c = 0; c < N_CHANNELS; c++) begin : g_drive
      assign o_test_out[c] = test_out_q[c];
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tp_ms_q     <= '0;
      tp_low_q    <= '0;
      tp_ch_q     <= 1'b0;
      other_pre_q <= 1'b0;
    end else begin
      if (ms_tick_q) begin
        tp_ms_q <= (tp_ms_q == TP_LAST) ? '0 : tp_ms_q + MS_W'(1);
      end
      if (tp_start) begin
        tp_low_q    <= LOW_LOAD;
        tp_ch_q     <= next_ch;
        other_pre_q <= raw[!next_ch];
      end else if (pulse_live) begin
        tp_low_q <= tp_low_q - LOW_W'(1);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      test_out_q  <= TEST_IDLE;
      test_prev_q <= TEST_IDLE;
    end else begin
      test_out_q  <= TEST_IDLE;
      if (test_on && pulse_live && !pulse_end) begin
        test_out_q[tp_ch_q] <= 1'b0;
      end
      test_prev_q <= test_out_q;
    end
  end

  // during a pulse and one cycle after, the filter sees the last level before it
  wire [N_CHANNELS-1:0] masked = ~test_out_q | ~test_prev_q;
  wire [N_CHANNELS-1:0] filt_in = (masked & hold_q) | (~masked & raw);

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_q <= FILT_RESET;
    end else begin
      hold_q <= filt_in;
    end
  end

  // debounce
  logic [N_CHANNELS-1:0] filt;

  sie_filter #(
    .N (N_CHANNELS)
  ) u_filter (
    .i_clock     (i_clock),
    .i_reset_n   (i_reset_n),
    .i_ms_tick   (ms_tick_q),
    .i_filter_ms (filter_ms),
    .i_raw       (filt_in),
    .o_filt      (filt)
  );

  // evaluation
  // equivalent pairs agree when equal, the NO+NC pair when different
  wire agree  = !two_ch || (mixed ? (filt[0] ^ filt[1]) : (filt[0] ~^ filt[1]));
  // gate closed, guard locked, key turned or area clear: first channel high
  wire active = agree && filt[0];
  wire idle   = agree && !filt[0];
  // the filter starts out inactive, so idle only counts once it has caught up with the inputs
  wire settled = filt_in == filt;

  // simultaneity
  logic [MS_W:0] skew_q;
  logic          simul_q;

  wire skew_over = skew_q > {1'b0, i_cfg.simul_ms};
  wire simul_evt = simul_on && !agree && skew_over;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      skew_q <= '0;
    end else if (!simul_on || agree) begin
      skew_q <= '0;
    end else if (ms_tick_q && !skew_over) begin
      skew_q <= skew_q + 9'h001;
    end
  end

  // faults stay until the inputs settle to a consistent idle; a new event wins over the clear
  wire fault_clear = idle;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      simul_q <= 1'b0;
      short_q <= 1'b0;
    end else begin
      if (simul_evt) begin
        simul_q <= 1'b1;
      end else if (fault_clear) begin
        simul_q <= 1'b0;
      end
      if (short_evt) begin
        short_q <= 1'b1;
      end else if (fault_clear) begin
        short_q <= 1'b0;
      end
    end
  end

  wire fault = simul_q || short_q || simul_evt || short_evt;
  wire good  = active && !fault;

  // output sequencing
  sie_state_t state_q;
  sie_state_t state_d;
  logic       safe_q;
  logic       error_q;
  logic       reset_ok;

  sie_reset_detect u_reset (
    .i_clock       (i_clock),
    .i_reset_n     (i_reset_n),
    .i_monitored   (i_cfg.reset_monitored),
    .i_arm         (state_q == ST_ARMED),
    .i_reset_input (i_reset_input),
    .o_accept      (reset_ok)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      // power-up test: a full release then actuation before anything can enable
      ST_TEST_OFF: begin
        if (!start_on) begin
          state_d = ST_OFF;
        end else if (idle && settled && !fault) begin
          state_d = ST_TEST_ON;
        end
      end
      ST_TEST_ON: begin
        if (good) begin
          state_d = reset_on ? ST_ARMED : ST_ON;
        end
      end
      ST_OFF: begin
        if (good) begin
          state_d = reset_on ? ST_ARMED : ST_ON;
        end
      end
      ST_ARMED: begin
        if (!good) begin
          state_d = ST_OFF;
        end else if (reset_ok) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (!good) begin
          state_d = ST_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_TEST_OFF;
      safe_q  <= 1'b0;
      error_q <= 1'b0;
    end else begin
      state_q <= state_d;
      safe_q  <= state_d == ST_ON;
      error_q <= i_cfg.error_en && fault;
    end
  end

  assign o_safe                   = safe_q;
  assign o_error                  = error_q;
  assign o_status.simul_fault     = simul_q;
  assign o_status.short_fault     = short_q;
  assign o_status.await_reset     = state_q == ST_ARMED;
  assign o_status.startup_pending = (state_q == ST_TEST_OFF) || (state_q == ST_TEST_ON);

endmodule // sie_evaluator

// ---- sie_field_model.sv ----
`timescale 1ns/1ps
module sie_field_model (
  // from the evaluator
  input  wire logic [1:0] i_test_out,
  // field state
  input  wire logic [1:0] i_close,
  input  wire logic       i_short,
  input  wire logic       i_push,
  // to the evaluator
  output logic            o_first,
  output logic            o_second,
  output logic            o_reset
);
  // a closed contact returns the test drive, so a pulse shows as a dip
  // a short to supply keeps the first line high and hides the pulse
  assign o_first  = i_short | (i_close[0] & i_test_out[0]);
  assign o_second = i_close[1] & i_test_out[1];
  // pushbutton on the input right after the two contacts
  assign o_reset  = i_push;
endmodule // sie_field_model

// ---- sie_evaluator_props.sv ----
`timescale 1ns/1ps
module sie_evaluator_props
  import sie_pkg::*;
#(
  parameter int P_CYC_PER_MS = sie_pkg::CYC_PER_MS
) (
  input wire logic                 i_clock,
  input wire logic                 i_reset_n,
  input wire sie_pkg::sie_cfg_t    i_cfg,
  input wire logic                 i_first_contact_input,
  input wire logic                 i_second_contact_input,
  input wire logic                 i_reset_input,
  input wire logic [1:0]           o_test_out,
  input wire logic                 o_safe,
  input wire logic                 o_error,
  input wire sie_pkg::sie_status_t o_status
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  wire logic fault = o_status.simul_fault | o_status.short_fault;
  wire logic mon   = i_cfg.reset_en & i_cfg.reset_monitored & (i_cfg.mode != SIE_MODE_LOCK);
  property p_err_off; !i_cfg.error_en |-> !o_error; endproperty
  a_err_off: assert property (p_err_off) else $error("error raised while disabled");
  property p_err_on; (i_cfg.error_en && fault)[*2] |-> o_error; endproperty
  a_err_on: assert property (p_err_on) else $error("fault without error output");
  property p_fault_low; fault[*3] |-> !o_safe; endproperty
  a_fault_low: assert property (p_fault_low) else $error("safe high during fault");
  property p_curt_test; i_cfg.mode == SIE_MODE_CURTAIN |-> o_test_out == 2'h3; endproperty
  a_curt_test: assert property (p_curt_test) else $error("curtain got test pulse");
  property p_test_idle; !i_cfg.test_en |-> o_test_out == 2'h3; endproperty
  a_test_idle: assert property (p_test_idle) else $error("pulse while tests off");
  property p_pulse; $fell(o_test_out[0]) |=> !o_test_out[0] [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("test pulse too short");
  property p_startup; o_status.startup_pending |-> !o_safe; endproperty
  a_startup: assert property (p_startup) else $error("safe high before startup test");
  property p_armed; o_status.await_reset[*2] |-> !o_safe; endproperty
  a_armed: assert property (p_armed) else $error("safe high while awaiting reset");
  property p_mon; (mon && i_reset_input)[*3] |-> !$rose(o_safe); endproperty
  a_mon: assert property (p_mon) else $error("monitored reset taken on rise");
endmodule // sie_evaluator_props
bind sie_evaluator sie_evaluator_props #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_props (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_cfg(i_cfg),
  .i_first_contact_input(i_first_contact_input), .i_second_contact_input(i_second_contact_input),
  .i_reset_input(i_reset_input), .o_test_out(o_test_out), .o_safe(o_safe),
  .o_error(o_error), .o_status(o_status));

// ---- tb_sie_evaluator.sv ----
`timescale 1ns/1ps
module tb_sie_evaluator;
  import sie_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_reset_n = 1'b0;
  sie_cfg_t    i_cfg = '0;
  logic [1:0]  close_v = 2'h0;
  logic        short_v = 1'b0;
  logic        push_v = 1'b0;
  logic        first_w, second_w, reset_w, o_safe, o_error;
  logic [1:0]  o_test_out;
  sie_status_t o_status;
  int          err_total = 0;
  int          checks_done = 0;
  sie_field_model u_field (.i_test_out(o_test_out), .i_close(close_v), .i_short(short_v),
    .i_push(push_v), .o_first(first_w), .o_second(second_w), .o_reset(reset_w));
  // short ms so filter, skew and pulse period fit a brief run
  sie_evaluator #(.P_CYC_PER_MS(10)) uut (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_cfg(i_cfg), .i_first_contact_input(first_w), .i_second_contact_input(second_w),
    .i_reset_input(reset_w), .o_test_out(o_test_out), .o_safe(o_safe), .o_error(o_error),
    .o_status(o_status));
  initial begin
    forever #20 i_clock = ~i_clock;
  end
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %b want %b", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // flags: reset_en, monitored, test_en, startup_en, simul_en, error_en
  task automatic setup(input sie_mode_t m, input sie_contact_t c, input logic [5:0] f);
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    i_cfg <= '{mode: m, contact: c, reset_en: f[5], reset_monitored: f[4], test_en: f[3],
               startup_en: f[2], simul_en: f[1], error_en: f[0], filter_ms: 8'h03,
               simul_ms: 8'h02};
    // contacts keep their last state through reset, so power-up may see them closed
    push_v <= 1'b0;
    short_v <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
  endtask
  task automatic drive(input logic [1:0] c, input logic p, input int n);
    @(posedge i_clock);
    close_v <= c;
    push_v <= p;
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic plain(input sie_mode_t m, input sie_contact_t c, input logic [1:0] act);
    setup(m, c, 6'h00);
    drive(act, 1'b0, 40);
    chk(o_safe, 1'b1);
    drive(2'h0, 1'b0, 40);
    chk(o_safe, 1'b0);
  endtask
  initial begin
    #(40 * 20000);
    err_total++;
    give_verdict();
  end
  initial begin
    plain(SIE_MODE_GATE, SIE_IN_SINGLE_NC, 2'h1);
    plain(SIE_MODE_LOCK, SIE_IN_SINGLE_NC, 2'h1);
    plain(SIE_MODE_LOCK, SIE_IN_DOUBLE_NC, 2'h3);
    plain(SIE_MODE_LOCK, SIE_IN_NC_NO, 2'h1);
    plain(SIE_MODE_KEY, SIE_IN_SINGLE_NO, 2'h1);
    plain(SIE_MODE_KEY, SIE_IN_DOUBLE_NO, 2'h3);
    plain(SIE_MODE_CURTAIN, SIE_IN_DOUBLE_NC, 2'h3);
    // filtered change must not pass before filter_ms - 1 ms
    setup(SIE_MODE_GATE, SIE_IN_SINGLE_NC, 6'h00);
    drive(2'h1, 1'b0, 19);
    chk(o_safe, 1'b0);
    drive(2'h1, 1'b0, 20);
    chk(o_safe, 1'b1);
    setup(SIE_MODE_GATE, SIE_IN_SINGLE_NC, 6'h21);
    drive(2'h1, 1'b0, 40);
    chk(o_status.await_reset, 1'b1);
    drive(2'h1, 1'b1, 3);
    chk(o_safe, 1'b1);
    drive(2'h0, 1'b0, 40);
    drive(2'h1, 1'b0, 40);
    chk(o_safe, 1'b0);
    setup(SIE_MODE_GATE, SIE_IN_SINGLE_NC, 6'h31);
    drive(2'h1, 1'b0, 40);
    drive(2'h1, 1'b1, 10);
    chk(o_safe, 1'b0);
    drive(2'h1, 1'b0, 3);
    chk(o_safe, 1'b1);
    // gate still closed from above: power-up must not count that as a test
    setup(SIE_MODE_GATE, SIE_IN_SINGLE_NC, 6'h04);
    drive(2'h1, 1'b0, 40);
    chk(o_safe, 1'b0);
    chk(o_status.startup_pending, 1'b1);
    drive(2'h0, 1'b0, 40);
    chk(o_status.startup_pending, 1'b1);
    drive(2'h1, 1'b0, 40);
    chk(o_safe, 1'b1);
    setup(SIE_MODE_KEY, SIE_IN_DOUBLE_NO, 6'h04);
    drive(2'h0, 1'b0, 40);
    chk(o_status.startup_pending, 1'b1);
    drive(2'h3, 1'b0, 40);
    chk(o_safe, 1'b1);
    setup(SIE_MODE_KEY, SIE_IN_SINGLE_NO, 6'h21);
    drive(2'h1, 1'b0, 40);
    chk(o_safe, 1'b0);
    drive(2'h1, 1'b1, 3);
    chk(o_safe, 1'b1);
    // mixed lock: both lines high is a skew that outlasts the 2 ms limit
    setup(SIE_MODE_LOCK, SIE_IN_NC_NO, 6'h03);
    drive(2'h1, 1'b0, 40);
    drive(2'h3, 1'b0, 70);
    chk(o_status.simul_fault, 1'b1);
    chk(o_error, 1'b1);
    chk(o_safe, 1'b0);
    drive(2'h2, 1'b0, 60);
    chk(o_status.simul_fault, 1'b0);
    drive(2'h1, 1'b0, 40);
    chk(o_safe, 1'b1);
    // curtain: skew checked with simul_en low, no pulses with test_en high
    setup(SIE_MODE_CURTAIN, SIE_IN_DOUBLE_NC, 6'h28);
    drive(2'h1, 1'b0, 70);
    chk(o_status.simul_fault, 1'b1);
    chk(o_error, 1'b0);
    chk(o_test_out, 2'h3);
    drive(2'h0, 1'b0, 40);
    drive(2'h3, 1'b0, 40);
    chk(o_safe, 1'b0);
    drive(2'h3, 1'b1, 3);
    chk(o_safe, 1'b1);
    // a pulse comes every 10 ms, so 300 cycles see at least two
    setup(SIE_MODE_GATE, SIE_IN_SINGLE_NC, 6'h09);
    drive(2'h1, 1'b0, 300);
    chk(o_status.short_fault, 1'b0);
    chk(o_safe, 1'b1);
    @(posedge i_clock);
    short_v <= 1'b1;
    drive(2'h1, 1'b0, 300);
    chk(o_status.short_fault, 1'b1);
    chk(o_error, 1'b1);
    chk(o_safe, 1'b0);
    give_verdict();
  end
endmodule // tb_sie_evaluator
